/* File: hdl/oss_mst.sv */
// Master end: clocks one framed word out and the status word back.
`timescale 1ns/1ps
module oss_mst #(
    parameter int NBITS = oss_pkg::CMD_W,
    parameter int FAULT_WAIT = oss_pkg::FAULT_CYC
) (
    input wire logic I_CLK, // System clock, 50 MHz.
    input wire logic I_RST_B, // Synchronous reset, active low.
    oss_if.mst link, // Serial link pins.
    input wire logic I_START, // Start a transfer, one-cycle pulse.
    input wire logic [NBITS-1:0] I_CMD, // Command word, MSB sent first.
    input wire logic I_GRANT, // This master may own the link.
    input wire logic I_DEV_RST, // Hold device reset pin low.
    output logic O_BUSY, // Transfer or fault wait in progress.
    output logic O_DONE, // Status word valid, one-cycle pulse.
    output logic [NBITS-1:0] O_STATUS // Returned status word.
);
    // *************************************************************
    // Parameter check.
    // *************************************************************
    generate
        if (NBITS < 2 || FAULT_WAIT < 1) begin : g_bad
            $error("Word width must be two or more, fault wait positive.");
        end
    endgenerate

    typedef enum logic [2:0] {
        IDLE, LEAD, HIGH, LOW, LAG, HOLD
    } oss_mst_st_t;

    localparam int BW = $clog2(NBITS + 1);
    oss_mst_st_t st_q;
    logic [31:0] cnt_q;
    logic [BW-1:0] bit_q;
    logic [NBITS-1:0] tx_q;
    logic [NBITS-1:0] rx_q;
    logic [NBITS-1:0] stat_q;
    logic sclk_q;
    logic cs_b_q;
    logic mosi_q;
    logic rst_b_q;
    logic done_q;
    logic so_s1_q;
    logic so_s2_q;
    logic last;
    logic all_bits;

    // *************************************************************
    // Phase timing.
    // *************************************************************

    // Half periods meet the slowest clock phase, the hold waits faults.
    assign last = (st_q == HOLD) ?
        (cnt_q == 32'(FAULT_WAIT - 1)) :
        (cnt_q == 32'(oss_pkg::HALF_CYC - 1));
    assign all_bits = (bit_q == BW'(NBITS));

    // Serial input passes two stages before use.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            so_s1_q <= 1'b1;
            so_s2_q <= 1'b1;
        end else begin
            so_s1_q <= link.so_line;
            so_s2_q <= so_s1_q;
        end
    end

    // *************************************************************
    // Frame sequencer.
    // *************************************************************

    // Clock stays low around select edges; data changes with clock rise.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            st_q <= IDLE;
            cnt_q <= '0;
            bit_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            stat_q <= '0;
            sclk_q <= 1'b0;
            cs_b_q <= 1'b1;
            mosi_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            cnt_q <= (st_q == IDLE || last) ? '0 : cnt_q + 32'd1;
            case (st_q)
                IDLE: begin
                    if (I_START && I_GRANT) begin
                        tx_q <= I_CMD;
                        mosi_q <= I_CMD[NBITS-1];
                        bit_q <= '0;
                        cs_b_q <= 1'b0;
                        st_q <= LEAD;
                    end
                end
                LEAD: begin
                    if (last) begin
                        sclk_q <= 1'b1;
                        st_q <= HIGH;
                    end
                end
                HIGH: begin
                    if (last) begin
                        sclk_q <= 1'b0;
                        rx_q <= {rx_q[NBITS-2:0], so_s2_q};
                        tx_q <= tx_q << 1;
                        bit_q <= bit_q + BW'(1);
                        st_q <= LOW;
                    end
                end
                LOW: begin
                    if (last) begin
                        if (all_bits) begin
                            st_q <= LAG;
                        end else begin
                            sclk_q <= 1'b1;
                            mosi_q <= tx_q[NBITS-1];
                            st_q <= HIGH;
                        end
                    end
                end
                LAG: begin
                    if (last) begin
                        cs_b_q <= 1'b1;
                        stat_q <= rx_q;
                        st_q <= HOLD;
                    end
                end
                HOLD: begin
                    if (last) begin
                        done_q <= 1'b1;
                        st_q <= IDLE;
                    end
                end
                default: begin
                    st_q <= IDLE;
                end
            endcase
        end
    end

    // Device reset pin follows the user request, registered.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            rst_b_q <= 1'b0;
        end else begin
            rst_b_q <= !I_DEV_RST;
        end
    end

    // *************************************************************
    // Outputs.
    // *************************************************************
    assign link.sclk = sclk_q;
    assign link.cs_b = cs_b_q;
    assign link.mosi = mosi_q;
    assign link.rst_b = rst_b_q;
    assign O_BUSY = (st_q != IDLE);
    assign O_DONE = done_q;
    assign O_STATUS = stat_q;
endmodule // oss_mst

/* File: inc/oss_pkg.sv */
// Shared constants for the octal low-side switch serial link.
// Notes on behaviour
// - Eight outputs, one command bit each.
// - Command bit 0 means ON, 1 means OFF.
// - Drain status returns during the command transfer.
// - Full duplex, one bit each way per clock.
// - Devices cascade through serial out to in.
// - Parallel devices share lines, separate chip selects.
// - One master drives the link at once.
// - Master waits fault report delay after select.
// - Protect disable low latches shorted output off.
// - Faulted output disabled even while deselected.
// - One output's fault leaves others untouched.
// - Select rise applies command, fall loads status.
// - Sample on clock fall, shift on rise.
// - Words travel MSB first, output 7 first.
// - Reset pin clears shifter, outputs off, keeps SO.
package oss_pkg;
    // *************************************************************
    // Word layout and reset values.
    // *************************************************************
    localparam int CMD_W = 8;
    localparam logic [7:0] CMD_ALL_OFF = 8'hFF;
    localparam logic [7:0] SHIFT_CLEAR = 8'h00;
    localparam logic SO_RESET = 1'h1;
    // Link pin samples after reset: select high, clock low, reset low.
    // Starting at the idle levels keeps a false select edge away.
    localparam logic [3:0] LINK_IDLE = 4'h4;
    // *************************************************************
    // Timing, in nanoseconds, microseconds and in cycles of the 50 MHz clock.
    // *************************************************************
    localparam int CLK_NS = 20;
    localparam int T_HALF_NS = 167;
    localparam int HALF_CYC = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_FAULT_US = 250;
    localparam int FAULT_CYC = (T_FAULT_US * 1000 + CLK_NS - 1) / CLK_NS;
endpackage

/* File: inc/oss_if.sv */
// Serial link between the switch device and its bus master.
`timescale 1ns/1ps
interface oss_if;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic rst_b;
    logic so;
    logic so_oe;
    logic so_line;
    // A released serial output reads high, as through a pull-up.
    assign so_line = so_oe ? so : 1'b1;
    modport dev (
        input sclk,
        input cs_b,
        input mosi,
        input rst_b,
        output so,
        output so_oe
    );
    modport mst (
        output sclk,
        output cs_b,
        output mosi,
        output rst_b,
        input so_line
    );
endinterface

/* File: hdl/oss_dev.sv */
// Device end: serial shifter, command latch and output fault logic.
`timescale 1ns/1ps
module oss_dev #(
    parameter int W = oss_pkg::CMD_W
) (
    input wire logic I_CLK, // System clock, 50 MHz.
    input wire logic I_RST_B, // Synchronous reset, active low.
    oss_if.dev link, // Serial link pins.
    input wire logic [W-1:0] I_SHORT, // Over-current sensed per output.
    input wire logic [W-1:0] I_OPEN, // Open load sensed per output.
    input wire logic I_SHORT_FAULT_LATCH_DISABLE, // High keeps limiting.
    output logic [W-1:0] O_OUT_ON, // Output switch conducting.
    output logic [W-1:0] O_LATCHED // Output latched off by a short.
);
    // *************************************************************
    // Parameter check.
    // *************************************************************
    generate
        if (W < 2) begin : g_bad_w
            $error("Word width must be at least two bits.");
        end
    endgenerate

    // *************************************************************
    // Input synchronisers.
    // *************************************************************
    localparam int NS = 2 * W + 5;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    logic [3:0] prv_q;

    // All pin inputs are gathered so one pair of stages serves them.
    assign raw = {I_SHORT_FAULT_LATCH_DISABLE, I_OPEN, I_SHORT,
        link.rst_b, link.cs_b, link.sclk, link.mosi};

    // Two stages, then one more stage of the link pins for edges.
    // The stages reset to the idle pin levels, so no edge follows reset.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            s1_q <= NS'(oss_pkg::LINK_IDLE);
            s2_q <= NS'(oss_pkg::LINK_IDLE);
            prv_q <= oss_pkg::LINK_IDLE;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            prv_q <= s2_q[3:0];
        end
    end

    // *************************************************************
    // Decoded pin states and edges.
    // *************************************************************
    logic si_s;
    logic sclk_s;
    logic cs_b_s;
    logic pin_rst_b_s;
    logic [W-1:0] short_s;
    logic [W-1:0] open_s;
    logic latch_dis_s;
    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;

    // Synchronised views of the pins.
    assign si_s = s2_q[0];
    assign sclk_s = s2_q[1];
    assign cs_b_s = s2_q[2];
    assign pin_rst_b_s = s2_q[3];
    assign short_s = s2_q[W+3:4];
    assign open_s = s2_q[2*W+3:W+4];
    assign latch_dis_s = s2_q[2*W+4];

    // Clock edges count only while selected before and after.
    assign sclk_fall = !cs_b_s && !prv_q[2] && prv_q[1] && !sclk_s;
    assign sclk_rise = !cs_b_s && !prv_q[2] && !prv_q[1] && sclk_s;
    assign cs_fall = prv_q[2] && !cs_b_s;
    assign cs_rise = !prv_q[2] && cs_b_s;

    // *************************************************************
    // State registers.
    // *************************************************************
    logic [W-1:0] shift_q;
    logic [W-1:0] shift_d;
    logic [W-1:0] cmd_q;
    logic [W-1:0] cmd_d;
    logic [W-1:0] latch_q;
    logic [W-1:0] latch_d;
    logic so_q;
    logic so_d;
    logic so_oe_q;
    logic [W-1:0] out_on_q;
    logic [W-1:0] on_cmd;
    logic [W-1:0] drain_hi;
    logic [W-1:0] short_hit;
    logic [W-1:0] latch_kept;

    // *************************************************************
    // Drain status and fault latch.
    // *************************************************************

    // A command bit of zero asks for the output to conduct.
    assign on_cmd = ~cmd_q;

    // Drain reads high when off and loaded, or when on and shorted.
    assign drain_hi = (on_cmd & (latch_q | short_s)) |
        (~on_cmd & ~open_s);

    // A short on an output that the applied command turns on latches
    // only that output off. The next command is used, so an output
    // that a new word switches off is never latched at select rise.
    assign short_hit = ~cmd_d & short_s & {W{!latch_dis_s}};

    // A new command or a reset pin pulse releases every latch.
    assign latch_kept = (cs_rise || !pin_rst_b_s) ? '0 : latch_q;

    // A short seen in the releasing cycle still latches; the set wins.
    assign latch_d = latch_kept | short_hit;

    // *************************************************************
    // Shifter, command latch and serial output.
    // *************************************************************

    // Select fall loads status, each clock fall takes one bit in.
    assign shift_d = !pin_rst_b_s ? oss_pkg::SHIFT_CLEAR :
        cs_fall ? drain_hi :
        sclk_fall ? {shift_q[W-2:0], si_s} :
        shift_q;

    // Select rise hands the shifted word to the outputs.
    assign cmd_d = !pin_rst_b_s ? oss_pkg::CMD_ALL_OFF :
        cs_rise ? shift_q :
        cmd_q;

    // The top bit leaves first and later holds bits for the next part.
    assign so_d = cs_fall ? drain_hi[W-1] :
        sclk_rise ? shift_q[W-1] :
        so_q;

    // Registered state; the reset pin leaves the serial output alone.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            shift_q <= oss_pkg::SHIFT_CLEAR;
            cmd_q <= oss_pkg::CMD_ALL_OFF;
            latch_q <= '0;
            so_q <= oss_pkg::SO_RESET;
            so_oe_q <= 1'b0;
            out_on_q <= '0;
        end else begin
            shift_q <= shift_d;
            cmd_q <= cmd_d;
            latch_q <= latch_d;
            so_q <= so_d;
            so_oe_q <= !cs_b_s;
            out_on_q <= ~cmd_d & ~latch_d;
        end
    end

    // *************************************************************
    // Outputs.
    // *************************************************************

    // Pins and switch drives come straight from flip-flops.
    assign link.so = so_q;
    assign link.so_oe = so_oe_q;
    assign O_OUT_ON = out_on_q;
    assign O_LATCHED = latch_q;
endmodule // oss_dev

/* File: tb/oss_asserts.sv */
// Concurrent checks on the serial link between master and device.
`timescale 1ns/1ps
module oss_asserts #(
    parameter int NBITS = oss_pkg::CMD_W
) (
    input wire logic I_CLK, // System clock.
    input wire logic I_RST_B, // Synchronous reset, active low.
    input wire logic sclk, // Serial clock.
    input wire logic cs_b, // Chip select, active low.
    input wire logic mosi, // Master data to device.
    input wire logic rst_b, // Device reset pin.
    input wire logic so_oe, // Device drives serial out.
    input wire logic so_line // Resolved serial out.
);
    // ****
    // Rising serial clock edges counted within one frame.
    // ****
    logic sclk_q;
    logic [7:0] rises_q;
    logic [7:0] rises_d;
    assign rises_d = cs_b ? 8'h00 : rises_q + {7'h00, sclk & ~sclk_q};
    // The counter restarts whenever the device is deselected.
    always_ff @(posedge I_CLK) begin
        sclk_q <= sclk;
        rises_q <= I_RST_B ? rises_d : 8'h00;
    end
    // ****
    // Link properties.
    // ****
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);
    a_sclk_idle: assert property (cs_b |-> !sclk)
        else $error("serial clock high outside a frame");
    a_cs_edge_low: assert property (
        $changed(cs_b) |-> !sclk && !$past(sclk))
        else $error("select moved with serial clock high");
    a_lead_time: assert property ($fell(cs_b) |-> !sclk [*8])
        else $error("serial clock rose too soon after select");
    a_high_phase: assert property ($rose(sclk) |-> sclk [*8])
        else $error("serial clock high phase too short");
    a_low_lag: assert property (
        $fell(sclk) |-> (!sclk && !cs_b) [*8])
        else $error("low phase or lag too short");
    a_mosi_steady: assert property (
        sclk && $past(sclk) |-> $stable(mosi))
        else $error("master data moved while clock high");
    a_frame_bits: assert property (
        $rose(cs_b) |-> rises_q == 8'(NBITS))
        else $error("frame clock count wrong");
    a_so_enable: assert property ($fell(cs_b) |-> ##[2:4] so_oe)
        else $error("serial out not driven in frame");
    a_so_release: assert property (cs_b [*5] |-> !so_oe)
        else $error("serial out driven while deselected");
    c_frame: cover property ($rose(cs_b));
    c_so_low: cover property (so_oe && !so_line);
    c_pin_rst: cover property ($fell(rst_b));
endmodule // oss_asserts

/* File: tb/tb.sv */
// Testbench: one master and device pair, plus a two-device chain.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    errors++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
    // ****
    // Stimulus, links and the ends under test.
    // ****
    logic clk = 1'b0;
    logic sys_rst_b = 1'b0;
    logic start = 1'b0;
    logic start2 = 1'b0;
    logic grant = 1'b0;
    logic dev_rst = 1'b0;
    logic dis = 1'b0;
    logic [7:0] cmd = 8'h00, sh = 8'h00, op = 8'h00, stat, out_on, lat_o;
    logic [7:0] out_a, out_b, c, nc, lat;
    logic [15:0] cmd2 = 16'h0000, stat2, c2, nc2, ex2;
    logic busy, busy2, done, done2;
    int errors = 0, comparisons = 0, i, n;
    oss_if l0();
    oss_if l1();
    oss_if la();
    oss_if lb();
    oss_mst #(.FAULT_WAIT(20)) oss_mst_i (.I_CLK(clk), .I_RST_B(sys_rst_b),
        .link(l0), .I_START(start), .I_CMD(cmd), .I_GRANT(grant),
        .I_DEV_RST(dev_rst), .O_BUSY(busy), .O_DONE(done), .O_STATUS(stat));
    oss_dev oss_dev_i (.I_CLK(clk), .I_RST_B(sys_rst_b), .link(l0),
        .I_SHORT(sh), .I_OPEN(op), .I_SHORT_FAULT_LATCH_DISABLE(dis),
        .O_OUT_ON(out_on), .O_LATCHED(lat_o));
    oss_mst #(.NBITS(16), .FAULT_WAIT(20)) oss_mst2_i (.I_CLK(clk),
        .I_RST_B(sys_rst_b), .link(l1), .I_START(start2), .I_CMD(cmd2),
        .I_GRANT(grant), .I_DEV_RST(dev_rst), .O_BUSY(busy2),
        .O_DONE(done2), .O_STATUS(stat2));
    oss_dev oss_deva_i (.I_CLK(clk), .I_RST_B(sys_rst_b), .link(la),
        .I_SHORT(8'h00), .I_OPEN(op), .I_SHORT_FAULT_LATCH_DISABLE(dis),
        .O_OUT_ON(out_a), .O_LATCHED());
    oss_dev oss_devb_i (.I_CLK(clk), .I_RST_B(sys_rst_b), .link(lb),
        .I_SHORT(8'h00), .I_OPEN(op), .I_SHORT_FAULT_LATCH_DISABLE(dis),
        .O_OUT_ON(out_b), .O_LATCHED());
    oss_asserts #(.NBITS(oss_pkg::CMD_W)) oss_asserts_i (.I_CLK(clk),
        .I_RST_B(sys_rst_b), .sclk(l0.sclk), .cs_b(l0.cs_b),
        .mosi(l0.mosi), .rst_b(l0.rst_b), .so_oe(l0.so_oe),
        .so_line(l0.so_line));
    // Chain: master data enters the first device, which feeds the second.
    assign la.sclk = l1.sclk;
    assign la.cs_b = l1.cs_b;
    assign la.rst_b = l1.rst_b;
    assign la.mosi = l1.mosi;
    assign lb.sclk = l1.sclk;
    assign lb.cs_b = l1.cs_b;
    assign lb.rst_b = l1.rst_b;
    assign lb.mosi = la.so_line;
    assign l1.so = lb.so;
    assign l1.so_oe = lb.so_oe;
    // 50 MHz clock.
    initial begin
        forever #10 clk = ~clk;
    end
    // ****
    // Helpers.
    // ****
    // Status of one device: ON and faulted, or OFF with no open load.
    function automatic logic [7:0] st(input logic [7:0] k, s, o);
        return (~k & s) | (k & ~o);
    endfunction
    // Pulses start on one master and waits, bounded, for its done pulse.
    task automatic xfer(input bit sel, input logic [15:0] w);
        int k;
        if (sel) begin
            start2 <= 1'b1;
            cmd2 <= w;
        end else begin
            start <= 1'b1;
            cmd <= w[7:0];
        end
        @(posedge clk);
        start <= 1'b0;
        start2 <= 1'b0;
        k = 0;
        while ((sel ? done2 : done) !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 2000) begin
            errors++;
            test_done;
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        test_done;
    end
    // ****
    // Test sequence.
    // ****
    initial begin
        n = $urandom(32'hb088);
        c = 8'hFF;
        lat = 8'h00;
        repeat (20) @(posedge clk);
        sys_rst_b <= 1'b1;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("busy", 1'b0, busy)
        grant <= 1'b1;
        for (i = 0; i < 40; i++) begin
            nc = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            if (i == 2) nc = 8'h7F;
            xfer(1'b0, {8'h00, nc});
            `CHK("status", st(c, sh | lat, op), stat)
            c = nc;
            lat = dis ? 8'h00 : ~c & sh;
            `CHK("out_on", ~c & ~lat, out_on)
            `CHK("latched", lat, lat_o)
            sh <= 8'($urandom & $urandom & $urandom);
            op <= 8'($urandom);
            dis <= 1'($urandom);
            repeat (8) @(posedge clk);
            lat = lat | (dis ? 8'h00 : ~c & sh);
            `CHK("fault_out", ~c & ~lat, out_on)
            `CHK("fault_lat", lat, lat_o)
            if (i == 20) begin
                dev_rst <= 1'b1;
                repeat (4) @(posedge clk);
                dev_rst <= 1'b0;
                repeat (6) @(posedge clk);
                c = 8'hFF;
                lat = 8'h00;
                `CHK("reset_out", 8'h00, out_on)
            end
        end
        c2 = 16'hFFFF;
        for (i = 0; i < 4; i++) begin
            nc2 = (i == 0) ? 16'h00FF : 16'($urandom);
            xfer(1'b1, nc2);
            ex2 = {st(c2[15:8], 8'h00, op), st(c2[7:0], 8'h00, op)};
            `CHK("chain_stat", ex2, stat2)
            `CHK("chain_out", ~nc2, {out_b, out_a})
            c2 = nc2;
        end
        `CHK("busy2", 1'b0, busy2)
        test_done;
    end
endmodule // tb
